// file: hw/vdc_call_chan.sv
// one call channel: delay, extend and combined delay/extend timing
`timescale 1ns/1ps
module vdc_call_chan #(
    parameter int TICK_CYCLES = vdc_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    // timing
    input  wire logic                     tick,
    // configuration
    input  wire logic [1:0]               mode,
    input  wire logic [vdc_pkg::TIME_W-1:0] delay_time,
    input  wire logic [vdc_pkg::TIME_W-1:0] extend_time,
    input  wire logic                     inhibit_exempt,
    // inputs
    input  wire logic                     presence,
    input  wire logic                     phase_green,
    input  wire logic                     force_call,
    // output
    output logic                          call_out
);
    vdc_pkg::vdc_ch_state_t state_r, state_nxt;
    logic [vdc_pkg::TIME_W-1:0] dly_r, dly_nxt;
    logic [vdc_pkg::TIME_W-1:0] ext_r, ext_nxt;
    logic                       call_r, call_nxt;
    logic                       use_dly, use_ext, hold_dly;

    assign use_dly  = (mode != vdc_pkg::CM_EXTEND);
    assign use_ext  = (mode == vdc_pkg::CM_EXTEND) || (mode == vdc_pkg::CM_DELAY_EXT);
    // normal delay pauses on green unless the controller type is exempt
    assign hold_dly = (mode == vdc_pkg::CM_NORM_DELAY) && phase_green && !inhibit_exempt;

    // next state of the channel
    always_comb begin
        state_nxt = state_r;
        dly_nxt   = dly_r;
        ext_nxt   = ext_r;
        call_nxt  = call_r;
        case (state_r)
            vdc_pkg::CH_IDLE: begin
                call_nxt = 1'b0;
                if (presence) begin
                    // zero delay bypasses the timer
                    if (!use_dly || delay_time == '0) begin
                        state_nxt = vdc_pkg::CH_CALL;
                        call_nxt  = 1'b1;
                        ext_nxt   = extend_time;
                    end else begin
                        state_nxt = vdc_pkg::CH_DELAY;
                        dly_nxt   = delay_time;
                    end
                end
            end
            vdc_pkg::CH_DELAY: begin
                if (!presence) begin
                    state_nxt = vdc_pkg::CH_IDLE;
                end else if (tick && !hold_dly) begin
                    if (dly_r <= 8'h01) begin
                        // call accepted only once delay has run out
                        state_nxt = vdc_pkg::CH_CALL;
                        call_nxt  = 1'b1;
                        ext_nxt   = extend_time;
                    end else begin
                        dly_nxt = dly_r - 8'h01;
                    end
                end
            end
            vdc_pkg::CH_CALL: begin
                call_nxt = 1'b1;
                if (presence) begin
                    ext_nxt = extend_time;
                end else if (!use_ext || ext_r == '0) begin
                    // back to idle: a new call must pass the delay again
                    state_nxt = vdc_pkg::CH_IDLE;
                    call_nxt  = 1'b0;
                end else if (tick) begin
                    // held through the extend time after the area empties
                    ext_nxt = ext_r - 8'h01;
                end
            end
            default: begin
                state_nxt = vdc_pkg::CH_IDLE;
                call_nxt  = 1'b0;
            end
        endcase
    end

    // registers of the channel
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= vdc_pkg::CH_IDLE;
            dly_r   <= '0;
            ext_r   <= '0;
            call_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dly_r   <= dly_nxt;
            ext_r   <= ext_nxt;
            call_r  <= call_nxt;
        end
    end

    // camera failure forces a constant call
    assign call_out = call_r || force_call;
endmodule

// file: hw/vdc_call_timing.sv
// top of the vehicle detection call conditioning block
// What this block does
// - a call reaches the controller output within 150 ms of a vehicle arriving.
// - full-time delay counts whenever a vehicle is present, whatever the phase.
// - normal delay is paused while the assigned phase is green unless exempt.
// - extend mode holds the call for the extend time after the vehicle leaves.
// - combined mode asserts a call only after the full-time delay has expired.
// - combined mode holds the call until the area is empty and extend has run out.
// - a vehicle entering during extend keeps the call and reloads the extend timer.
// - after extend expires a new call needs the delay to expire again.
// - each zone works as presence, directional presence, pulse or directional pulse.
// - eight independent zones are supported per camera.
// - four call outputs are driven toward the controller.
// - zones may overlap and each zone evaluates its own presence input.
// - zone and channel settings may be changed at any time and take effect one cycle later, all together.
// - a failed camera forces constant calls on every output that depends on it.

// ************************************************************
// limitations
// ************************************************************
// timers step on a 100 ms tick, so the first step of a delay or extend may be short.
// a pulse zone holds its call for a fixed 100 ms from each rising entry.
// settings pass one shadow flop so an edit lands on every zone and channel together.
`timescale 1ns/1ps
module vdc_call_timing (
    // clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         sys_rst,
    // zone detection from the image processor
    input  wire logic [7:0]                   zone_presence,
    input  wire logic [7:0]                   zone_dir_ok,
    // zone configuration, two bits per zone
    input  wire logic [15:0]                  zone_mode,
    // zone to channel map, two bits per zone
    input  wire logic [15:0]                  zone_chan,
    // channel configuration
    input  wire logic [7:0]                   chan_mode,
    input  wire logic [31:0]                  chan_delay,
    input  wire logic [31:0]                  chan_extend,
    input  wire logic [3:0]                   chan_inhibit_exempt,
    // controller and camera status
    input  wire logic [3:0]                   phase_green,
    input  wire logic                         camera_fail,
    // call outputs to the controller
    output logic [3:0]                        det_call
);
    // ************************************************************
    // tick divider for timer steps
    // ************************************************************
    logic [24:0] div_r, div_nxt;
    logic        tick;

    // a tick every 100 ms; timing is coarse to keep counters narrow
    always_comb begin
        div_nxt = (div_r == 25'(vdc_pkg::TICK_CYCLES - 1)) ? '0 : div_r + 25'h0000001;
    end
    // divider register, cleared by reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) div_r <= '0;
        else         div_r <= div_nxt;
    end
    // one-cycle enable when the divider wraps
    assign tick = (div_r == 25'(vdc_pkg::TICK_CYCLES - 1));

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [7:0] pres_s1_r, pres_s2_r, dir_s1_r, dir_s2_r;
    logic [3:0] grn_s1_r, grn_s2_r;
    logic       fail_s1_r, fail_s2_r;

    // two flops for every asynchronous level
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pres_s1_r <= '0;
            pres_s2_r <= '0;
            dir_s1_r  <= '0;
            dir_s2_r  <= '0;
            grn_s1_r  <= '0;
            grn_s2_r  <= '0;
            fail_s1_r <= 1'b0;
            fail_s2_r <= 1'b0;
        end else begin
            pres_s1_r <= zone_presence;
            pres_s2_r <= pres_s1_r;
            dir_s1_r  <= zone_dir_ok;
            dir_s2_r  <= dir_s1_r;
            grn_s1_r  <= phase_green;
            grn_s2_r  <= grn_s1_r;
            fail_s1_r <= camera_fail;
            fail_s2_r <= fail_s1_r;
        end
    end

    // ************************************************************
    // configuration shadow
    // ************************************************************
    logic [15:0] zmode_r, zmode_nxt;
    logic [15:0] zchan_r, zchan_nxt;
    logic [7:0]  cmode_r, cmode_nxt;
    logic [31:0] cdly_r, cdly_nxt;
    logic [31:0] cext_r, cext_nxt;
    logic [3:0]  cexm_r, cexm_nxt;

    // settings are taken on one edge so an edit reaches every zone and channel together;
    // the cost is one cycle, hidden behind the two sync flops of the presence path
    always_comb begin
        zmode_nxt = zone_mode;
        zchan_nxt = zone_chan;
        cmode_nxt = chan_mode;
        cdly_nxt  = chan_delay;
        cext_nxt  = chan_extend;
        cexm_nxt  = chan_inhibit_exempt;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            zmode_r <= '0;
            zchan_r <= '0;
            cmode_r <= '0;
            cdly_r  <= '0;
            cext_r  <= '0;
            cexm_r  <= '0;
        end else begin
            zmode_r <= zmode_nxt;
            zchan_r <= zchan_nxt;
            cmode_r <= cmode_nxt;
            cdly_r  <= cdly_nxt;
            cext_r  <= cext_nxt;
            cexm_r  <= cexm_nxt;
        end
    end

    // ************************************************************
    // zone evaluation
    // ************************************************************
    logic [7:0]  zone_act;
    logic [7:0]  prev_act_r, prev_act_nxt;
    logic [7:0]  zone_hit;
    logic [25:0] pcnt_r   [8];
    logic [25:0] pcnt_nxt [8];

    // directional modes need the motion direction to agree
    function automatic logic zone_active(input logic [1:0] m, input logic p, input logic d);
        zone_active = p && ((m == vdc_pkg::ZM_PRESENCE) || (m == vdc_pkg::ZM_PULSE) || d);
    endfunction

    // both pulse modes share the fixed-width stretcher
    function automatic logic is_pulse(input logic [1:0] m);
        is_pulse = (m == vdc_pkg::ZM_PULSE) || (m == vdc_pkg::ZM_DIR_PULSE);
    endfunction

    // each zone has its own input, so overlapping zones see a vehicle independently
    generate
        for (genvar z = 0; z < vdc_pkg::NUM_ZONES; z++) begin : g_zone
            // zone activity from synced presence and direction
            assign zone_act[z] = zone_active(zmode_r[2*z+:2], pres_s2_r[z],
                                             dir_s2_r[z]);
            // pulse width counter restarts on each rising entry
            always_comb begin
                pcnt_nxt[z] = pcnt_r[z];
                if (zone_act[z] && !prev_act_r[z]) begin
                    pcnt_nxt[z] = 26'(vdc_pkg::PULSE_CYCLES);
                end else if (pcnt_r[z] != '0) begin
                    pcnt_nxt[z] = pcnt_r[z] - 26'h0000001;
                end
            end
            // pulse counter register
            always_ff @(posedge core_clk) begin
                if (sys_rst) pcnt_r[z] <= '0;
                else         pcnt_r[z] <= pcnt_nxt[z];
            end
            // a pulse zone reports its counter, a presence zone its activity
            assign zone_hit[z] = is_pulse(zmode_r[2*z+:2]) ? (pcnt_r[z] != '0)
                                                              : zone_act[z];
        end
    endgenerate

    // last cycle's activity, for the entry edge of pulse zones
    always_comb begin
        prev_act_nxt = zone_act;
    end
    // cleared by reset so no false entry edge follows it
    always_ff @(posedge core_clk) begin
        if (sys_rst) prev_act_r <= '0;
        else         prev_act_r <= prev_act_nxt;
    end

    // ************************************************************
    // call channels
    // ************************************************************
    // presence seen by each channel after the zone map
    logic [3:0] chan_pres;

    // or together every zone mapped to a channel; the map is the shadow copy, so edits apply one cycle later
    always_comb begin
        chan_pres = '0;
        for (int z = 0; z < vdc_pkg::NUM_ZONES; z++) begin
            chan_pres[zchan_r[2*z+:2]] = chan_pres[zchan_r[2*z+:2]] | zone_hit[z];
        end
    end

    // input path is two sync flops plus one state flop, and the pulse counter flop too for pulse zones, far inside 150 ms
    generate
        for (genvar c = 0; c < vdc_pkg::NUM_CALLS; c++) begin : g_chan
            vdc_call_chan u_chan (
                .core_clk       (core_clk),
                .sys_rst        (sys_rst),
                .tick           (tick),
                .mode           (cmode_r[2*c+:2]),
                .delay_time     (cdly_r[8*c+:8]),
                .extend_time    (cext_r[8*c+:8]),
                .inhibit_exempt (cexm_r[c]),
                .presence       (chan_pres[c]),
                .phase_green    (grn_s2_r[c]),
                .force_call     (fail_s2_r),
                .call_out       (det_call[c])
            );
        end
    endgenerate
endmodule

// file: hw/vdc_pkg.sv
// package of constants and types for the vehicle call timing block
package vdc_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_ZONES    = 8;
    localparam int NUM_CALLS    = 4;
    localparam int TIME_W       = 8;
    // ************************************************************
    // timing: one tick is 100 ms
    // ************************************************************
    localparam int CLK_MHZ      = 200;
    localparam int TICK_MS      = 100;
    localparam int TICK_CYCLES  = CLK_MHZ * 1000 * TICK_MS;
    localparam int PULSE_MS     = 100;
    localparam int PULSE_CYCLES = CLK_MHZ * 1000 * PULSE_MS;
    localparam int LATENCY_MS   = 150;
    localparam int LATENCY_CYCLES = CLK_MHZ * 1000 * LATENCY_MS;
    // ************************************************************
    // zone modes
    // ************************************************************
    localparam logic [1:0] ZM_PRESENCE  = 2'h0;
    localparam logic [1:0] ZM_DIR_PRES  = 2'h1;
    localparam logic [1:0] ZM_PULSE     = 2'h2;
    localparam logic [1:0] ZM_DIR_PULSE = 2'h3;
    // ************************************************************
    // call channel delay modes
    // ************************************************************
    localparam logic [1:0] CM_FULL_DELAY = 2'h0;
    localparam logic [1:0] CM_NORM_DELAY = 2'h1;
    localparam logic [1:0] CM_EXTEND     = 2'h2;
    localparam logic [1:0] CM_DELAY_EXT  = 2'h3;
    // channel state, one-hot
    typedef enum logic [2:0] {
        CH_IDLE  = 3'h1,
        CH_DELAY = 3'h2,
        CH_CALL  = 3'h4
    } vdc_ch_state_t;
endpackage

// file: tb/tb.sv
// self-checking bench for the vehicle call timing block
`timescale 1ns/1ps
module tb;
    // ************************************************************
    // signals
    // ************************************************************
    logic        core_clk, sys_rst, camera_fail;
    logic [7:0]  zone_presence, zone_dir_ok, chan_mode;
    logic [15:0] zone_mode, zone_chan;
    logic [31:0] chan_delay, chan_extend;
    logic [3:0]  chan_inhibit_exempt, phase_green, det_call;
    logic [1:0]  dmodes [3];
    int          failures = 0;
    int          compares = 0;
    int          cycles = 0;
    vdc_call_timing vdc_call_timing_inst (.core_clk, .sys_rst, .zone_presence, .zone_dir_ok,
        .zone_mode, .zone_chan, .chan_mode, .chan_delay, .chan_extend,
        .chan_inhibit_exempt, .phase_green, .camera_fail, .det_call);
    vdc_ctrl_model #(.LAG(20)) vdc_ctrl_model_inst (.core_clk, .sys_rst, .det_call,
        .phase_green);
    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // hang guard, the run needs under 1500 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input logic [3:0] exp, input string msg);
        compares++;
        if (det_call !== exp) begin
            failures++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // presence in, call out; then zone 1 overlapping on channel 2 and remapped live
    task automatic t_map();
        zone_presence = 8'h01;
        cyc(4);
        chk(4'h1, "no call");
        zone_presence = 8'h00;
        cyc(4);
        chk(4'h0, "call held");
        zone_chan[3:2] = 2'h2;
        zone_presence = 8'h03;
        cyc(4);
        chk(4'h5, "overlap");
        zone_chan[3:2] = 2'h1;
        cyc(4);
        chk(4'h3, "remap");
        zone_presence = 8'h80;
        cyc(4);
        chk(4'h8, "zone 7");
        zone_presence = 8'h00;
        cyc(4);
    endtask
    // directional presence gated by travel direction
    task automatic t_dir();
        zone_mode[1:0] = vdc_pkg::ZM_DIR_PRES;
        zone_presence = 8'h01;
        cyc(6);
        chk(4'h0, "wrong direction");
        zone_dir_ok = 8'h01;
        cyc(4);
        chk(4'h1, "right direction");
        zone_presence = 8'h00;
        zone_mode = 16'h0000;
        cyc(4);
    endtask
    // delay modes hold off the call; zero delay bypasses
    task automatic t_delay();
        dmodes = '{vdc_pkg::CM_FULL_DELAY, vdc_pkg::CM_NORM_DELAY, vdc_pkg::CM_DELAY_EXT};
        chan_delay[7:0] = 8'h02;
        foreach (dmodes[i]) begin
            chan_mode[1:0] = dmodes[i];
            zone_presence = 8'h01;
            cyc(200);
            chk(4'h0, "call before delay");
            zone_presence = 8'h00;
            cyc(4);
        end
        chan_delay[7:0] = 8'h00;
        chan_mode[1:0] = vdc_pkg::CM_FULL_DELAY;
        zone_presence = 8'h01;
        cyc(4);
        chk(4'h1, "zero delay");
        zone_presence = 8'h00;
        chan_mode[1:0] = vdc_pkg::CM_EXTEND;
        cyc(4);
    endtask
    // extend and combined modes hold the call after the area empties; a switch to
    // full delay clears the held call, as a tick is far beyond the run length
    task automatic t_extend();
        chan_delay[7:0] = 8'h00;
        chan_extend[7:0] = 8'h01;
        dmodes[0] = vdc_pkg::CM_EXTEND;
        dmodes[1] = vdc_pkg::CM_DELAY_EXT;
        for (int i = 0; i < 2; i++) begin
            chan_mode[1:0] = dmodes[i];
            zone_presence = 8'h01;
            cyc(4);
            chk(4'h1, "no extend call");
            zone_presence = 8'h00;
            cyc(8);
            chk(4'h1, "extend dropped");
            zone_presence = 8'h01;
            cyc(2);
            zone_presence = 8'h00;
            cyc(8);
            chk(4'h1, "re-entry dropped");
            chan_mode[1:0] = vdc_pkg::CM_FULL_DELAY;
            cyc(4);
            chk(4'h0, "call not cleared");
        end
        chan_mode[1:0] = vdc_pkg::CM_EXTEND;
        chan_extend[7:0] = 8'h00;
        cyc(2);
    endtask
    // camera failure forces every call, pulses run last as they last 100 ms
    task automatic t_fail_pulse();
        camera_fail = 1'b1;
        cyc(3);
        chk(4'hF, "fail");
        camera_fail = 1'b0;
        cyc(4);
        chk(4'h0, "stuck");
        zone_chan[7:4] = 4'h7;
        zone_mode[7:4] = {vdc_pkg::ZM_DIR_PULSE, vdc_pkg::ZM_PULSE};
        zone_dir_ok = 8'h08;
        zone_presence = 8'h04;
        cyc(4);
        zone_presence = 8'h08;
        cyc(4);
        zone_presence = 8'h00;
        cyc(50);
        chk(4'hA, "pulse");
    endtask
    // reset, then the scenarios
    initial begin
        sys_rst = 1'b1;
        camera_fail = 1'b0;
        zone_presence = 8'h00;
        zone_dir_ok = 8'h00;
        zone_mode = 16'h0000;
        zone_chan = 16'hE4E4;
        chan_mode = 8'hAA;
        chan_delay = 32'h0000_0000;
        chan_extend = 32'h0000_0000;
        chan_inhibit_exempt = 4'h0;
        cyc(10);
        chk(4'h0, "reset");
        sys_rst = 1'b0;
        cyc(2);
        t_map();
        t_dir();
        t_delay();
        t_extend();
        t_fail_pulse();
        end_of_test();
    end
endmodule

// file: tb/vdc_call_timing_properties.sv
// concurrent checks on the ports of the call timing block
`timescale 1ns/1ps
module vdc_call_timing_props (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // zone and channel inputs
    input wire logic [7:0]  zone_presence,
    input wire logic [7:0]  zone_dir_ok,
    input wire logic [15:0] zone_mode,
    input wire logic [15:0] zone_chan,
    input wire logic [7:0]  chan_mode,
    input wire logic [31:0] chan_delay,
    input wire logic [31:0] chan_extend,
    input wire logic [3:0]  chan_inhibit_exempt,
    input wire logic [3:0]  phase_green,
    input wire logic        camera_fail,
    // calls
    input wire logic [3:0]  det_call
);
    // ************************************************************
    // reset, camera failure and channel 0, 2 and 3 checks
    // ************************************************************
    logic cfg0_ok;
    // channel 0 bypassed extend, no pulse zone able to stretch the call
    assign cfg0_ok = !camera_fail && chan_mode[1:0] == 2'h2 && chan_extend[7:0] == 8'h00
                     && zone_mode[15:2] == 14'h0000 && !zone_mode[1];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_empty0;
        (cfg0_ok && zone_presence == 8'h00)[*3];
    endsequence
    sequence s_wrong_dir0;
        (cfg0_ok && zone_presence == 8'h01 && zone_dir_ok == 8'h00 && zone_mode[0])[*3];
    endsequence
    property p_rst_clear;
        $fell(sys_rst) |-> det_call == 4'h0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("call out of reset");
    property p_fail_all;
        camera_fail [*2] |=> det_call == 4'hF;
    endproperty
    a_fail_all: assert property (p_fail_all) else $error("fail not forcing calls");
    property p_lat_z0;
        $rose(zone_presence[0]) && zone_mode[1:0] == 2'h0 && zone_chan[1:0] == 2'h0
            && chan_mode[1:0] == 2'h2 |-> ##[1:3] det_call[0];
    endproperty
    a_lat_z0: assert property (p_lat_z0) else $error("call late");
    property p_lat_z1;
        $rose(zone_presence[1]) && zone_mode[3:2] == 2'h0 && zone_chan[3:2] == 2'h2
            && chan_mode[5:4] == 2'h2 |-> ##[1:3] det_call[2];
    endproperty
    a_lat_z1: assert property (p_lat_z1) else $error("zone 1 call late");
    property p_drop;
        s_empty0 |=> !det_call[0];
    endproperty
    a_drop: assert property (p_drop) else $error("call held");
    property p_dir;
        s_wrong_dir0 |=> !det_call[0];
    endproperty
    a_dir: assert property (p_dir) else $error("wrong direction called");
    property p_delay;
        $rose(zone_presence[0]) && zone_presence[7:1] == 7'h00 && !camera_fail && !det_call[0]
            && chan_mode[1:0] != 2'h2 && chan_delay[7:0] >= 8'h02 && zone_mode[1:0] == 2'h0
            && zone_chan[1:0] == 2'h0 |=> (!det_call[0]) [*8];
    endproperty
    a_delay: assert property (p_delay) else $error("call before delay");
    property p_pulse;
        $rose(det_call[3]) && zone_mode[5:4] == 2'h2 && zone_chan[5:4] == 2'h3
            && zone_presence == 8'h04 && !camera_fail |=> det_call[3] [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse too short");
endmodule
bind vdc_call_timing vdc_call_timing_props vdc_call_timing_props_inst (.core_clk, .sys_rst,
    .zone_presence, .zone_dir_ok, .zone_mode, .zone_chan, .chan_mode, .chan_delay,
    .chan_extend, .chan_inhibit_exempt, .phase_green, .camera_fail, .det_call);

// file: tb/vdc_ctrl_model.sv
// behavioural signal controller that serves detector calls with green
`timescale 1ns/1ps
module vdc_ctrl_model #(
    parameter int LAG = 20
) (
    // clock, reset, calls in
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] det_call,
    // greens out
    output logic [3:0]      phase_green
);
    int wait_r [4];
    // a called phase goes green LAG+1 cycles after its call; a slow LAG mimics a busy cycle
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (sys_rst || !det_call[i]) begin
                wait_r[i]      <= 0;
                phase_green[i] <= 1'b0;
            end else if (wait_r[i] < LAG) begin
                wait_r[i] <= wait_r[i] + 1;
            end else begin
                phase_green[i] <= 1'b1;
            end
        end
    end
endmodule
